// >>> core/sram_tap_regs.vh
// Constants of the SRAM boundary-scan test access port
`ifndef SRAM_TAP_REGS_VH
`define SRAM_TAP_REGS_VH
`define OP_WIDTH      3
`define OP_EXTEST     3'h0
`define OP_IDREAD     3'h1
`define OP_SAMPLEZ    3'h2
`define OP_SAMPLE     3'h4
`define OP_BYPASS     3'h7
`define OP_RESET      3'h1
`define OP_CAPTURE    3'h1
`define ID_WIDTH      32
`define ID_VALUE      32'h0000_0001
`define CHAIN_LEN     109
`define FIFO_DEPTH    8
`define SYNC_STAGES   3
`endif

// >>> core/sram_boundary_scan_tap.v
// Boundary-scan test access port of the SRAM, with sample FIFO
`timescale 1ns/1ns
`include "sram_tap_regs.vh"

module sample_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             mclk,
   input  wire             rst,
   input  wire [WIDTH-1:0] inData,
   input  wire             inValid,
   output wire             inReady,
   output wire [WIDTH-1:0] outData,
   output wire             outValid,
   input  wire             outReady
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0]    wrPtr_q;
   reg [AW-1:0]    rdPtr_q;
   reg [AW:0]      count_q;
   wire            push;
   wire            pop;

   // Honest full and empty flags from the occupancy count
   assign inReady  = (count_q != DEPTH[AW:0]);
   assign outValid = (count_q != {(AW+1){1'b0}});
   assign outData  = mem_q[rdPtr_q];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   // Storage written at the write index
   always @(posedge mclk) begin
      if (push) begin
         mem_q[wrPtr_q] <= inData;
      end
   end

   // Pointers and count
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         wrPtr_q <= {AW{1'b0}};
         rdPtr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
         end
         count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule

module sram_boundary_scan_tap (
   input  wire                    mclk,
   input  wire                    rst,
   input  wire                    tck,
   input  wire                    tms,
   input  wire                    tdi,
   output reg                     tdo,
   output reg                     tdoEn_n,
   input  wire [`CHAIN_LEN-1:0]   pinIn,
   input  wire [`CHAIN_LEN-1:0]   sampleData,
   input  wire                    sampleValid,
   output wire                    sampleReady,
   output reg  [`CHAIN_LEN-1:0]   pinOut,
   output wire                    pinsFromScan,
   output wire                    memOutFloat,
   output reg                     outDataLost,
   output wire [3:0]              tapState,
   output wire [`OP_WIDTH-1:0]    opcode
);
   // Controller states, standard binary codes
   localparam S_EXIT2DR  = 4'h0;
   localparam S_EXIT1DR  = 4'h1;
   localparam S_SHIFTDR  = 4'h2;
   localparam S_PAUSEDR  = 4'h3;
   localparam S_SELIR    = 4'h4;
   localparam S_UPDDR    = 4'h5;
   localparam S_CAPDR    = 4'h6;
   localparam S_SELDR    = 4'h7;
   localparam S_EXIT2IR  = 4'h8;
   localparam S_EXIT1IR  = 4'h9;
   localparam S_SHIFTIR  = 4'hA;
   localparam S_PAUSEIR  = 4'hB;
   localparam S_IDLE     = 4'hC;
   localparam S_UPDIR    = 4'hD;
   localparam S_CAPIR    = 4'hE;
   localparam S_TLR      = 4'hF;

   reg  [`SYNC_STAGES-1:0]  tckS_q;
   reg  [`SYNC_STAGES-1:0]  tmsS_q;
   reg  [`SYNC_STAGES-1:0]  tdiS_q;
   reg                      tckF_q;
   reg                      tmsF_q;
   reg                      tdiF_q;
   reg  [3:0]               state_q;
   reg  [3:0]               state_d;
   reg  [`OP_WIDTH-1:0]     op_q;
   reg  [`OP_WIDTH-1:0]     opShift_q;
   reg                      shortcut_q;
   reg  [`ID_WIDTH-1:0]     idShift_q;
   reg  [`CHAIN_LEN:1]      chain_q;
   reg                      serialOut;
   wire                     tckRise;
   wire                     tckFall;
   wire                     chainSel;
   wire [`CHAIN_LEN-1:0]    fifoData;
   wire                     fifoValid;
   wire                     fifoPop;
   wire [`CHAIN_LEN-1:0]    captureWord;

   // Three-stage synchronisers for the test pins
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         tckS_q <= {`SYNC_STAGES{1'b0}};
         tmsS_q <= {`SYNC_STAGES{1'b1}};
         tdiS_q <= {`SYNC_STAGES{1'b1}};
      end else begin
         tckS_q <= {tckS_q[1:0], tck};
         tmsS_q <= {tmsS_q[1:0], tms};
         tdiS_q <= {tdiS_q[1:0], tdi};
      end
   end

   // Filtered levels follow once second and third stages agree
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         tckF_q <= 1'b0;
         tmsF_q <= 1'b1;
         tdiF_q <= 1'b1;
      end else begin
         if (tckS_q[1] == tckS_q[2]) begin
            tckF_q <= tckS_q[2];
         end
         if (tmsS_q[1] == tmsS_q[2]) begin
            tmsF_q <= tmsS_q[2];
         end
         if (tdiS_q[1] == tdiS_q[2]) begin
            tdiF_q <= tdiS_q[2];
         end
      end
   end

   // Test clock edges found on the filtered level
   assign tckRise = (tckS_q[1] & tckS_q[2]) & ~tckF_q;
   assign tckFall = ~(tckS_q[1] | tckS_q[2]) & tckF_q;

   // Next controller state from TMS at a rising edge
   always @* begin
      case (state_q)
         S_TLR:     state_d = tmsF_q ? S_TLR     : S_IDLE;
         S_IDLE:    state_d = tmsF_q ? S_SELDR   : S_IDLE;
         S_SELDR:   state_d = tmsF_q ? S_SELIR   : S_CAPDR;
         S_CAPDR:   state_d = tmsF_q ? S_EXIT1DR : S_SHIFTDR;
         S_SHIFTDR: state_d = tmsF_q ? S_EXIT1DR : S_SHIFTDR;
         S_EXIT1DR: state_d = tmsF_q ? S_UPDDR   : S_PAUSEDR;
         S_PAUSEDR: state_d = tmsF_q ? S_EXIT2DR : S_PAUSEDR;
         S_EXIT2DR: state_d = tmsF_q ? S_UPDDR   : S_SHIFTDR;
         S_UPDDR:   state_d = tmsF_q ? S_SELDR   : S_IDLE;
         S_SELIR:   state_d = tmsF_q ? S_TLR     : S_CAPIR;
         S_CAPIR:   state_d = tmsF_q ? S_EXIT1IR : S_SHIFTIR;
         S_SHIFTIR: state_d = tmsF_q ? S_EXIT1IR : S_SHIFTIR;
         S_EXIT1IR: state_d = tmsF_q ? S_UPDIR   : S_PAUSEIR;
         S_PAUSEIR: state_d = tmsF_q ? S_EXIT2IR : S_PAUSEIR;
         S_EXIT2IR: state_d = tmsF_q ? S_UPDIR   : S_SHIFTIR;
         S_UPDIR:   state_d = tmsF_q ? S_SELDR   : S_IDLE;
         default:   state_d = S_TLR;
      endcase
   end

   // Controller and opcode registers, advanced on rising TCK
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q   <= S_TLR;
         op_q      <= `OP_RESET;
         opShift_q <= `OP_CAPTURE;
      end else if (tckRise) begin
         state_q <= state_d;
         case (state_q)
            S_CAPIR:   opShift_q <= `OP_CAPTURE;
            S_SHIFTIR: opShift_q <= {tdiF_q, opShift_q[`OP_WIDTH-1:1]};
            default:   opShift_q <= opShift_q;
         endcase
         // Opcode takes effect on entry, so drivers switch as Update-IR begins
         if (state_d == S_TLR) begin
            op_q <= `OP_RESET;
         end else if (state_d == S_UPDIR) begin
            op_q <= opShift_q;
         end
      end
   end

   // Pin chain used by external test and both sample opcodes
   assign chainSel = (op_q == `OP_EXTEST) | (op_q == `OP_SAMPLEZ) | (op_q == `OP_SAMPLE);

   // Queued memory-side samples take precedence over live pins
   assign fifoPop     = tckRise & (state_q == S_CAPDR) & chainSel;
   assign captureWord = fifoValid ? fifoData : pinIn;

   sample_fifo #(
      .WIDTH (`CHAIN_LEN),
      .DEPTH (`FIFO_DEPTH),
      .AW    (3)
   ) u_fifo (
      .mclk     (mclk),
      .rst      (rst),
      .inData   (sampleData),
      .inValid  (sampleValid),
      .inReady  (sampleReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (fifoPop)
   );

   // Data registers: capture and shift on rising TCK
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         shortcut_q <= 1'b0;
         idShift_q  <= {`ID_WIDTH{1'b0}};
         chain_q    <= {`CHAIN_LEN{1'b0}};
      end else if (tckRise) begin
         if (state_q == S_CAPDR) begin
            shortcut_q <= 1'b0;
            if (op_q == `OP_IDREAD) begin
               idShift_q <= `ID_VALUE;
            end
            if (chainSel) begin
               chain_q <= captureWord;
            end
         end else if (state_q == S_SHIFTDR) begin
            shortcut_q <= tdiF_q;
            if (op_q == `OP_IDREAD) begin
               idShift_q <= {tdiF_q, idShift_q[`ID_WIDTH-1:1]};
            end
            if (chainSel) begin
               chain_q <= {tdiF_q, chain_q[`CHAIN_LEN:2]};
            end
         end
      end
   end

   // Preload latch driven onto pins on Update-DR
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         pinOut <= {`CHAIN_LEN{1'b0}};
      end else if (tckRise && state_q == S_UPDDR && chainSel) begin
         pinOut <= chain_q;
      end
   end

   // Pin drive selection by the active opcode
   assign pinsFromScan = (op_q == `OP_EXTEST);
   assign memOutFloat  = (op_q == `OP_SAMPLEZ);

   // Output data register marked lost once external test is loaded
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         outDataLost <= 1'b0;
      end else if (op_q == `OP_EXTEST) begin
         outDataLost <= 1'b1;
      end
   end

   // Serial output selection; reserved opcodes fall to the shortcut
   always @* begin
      if (state_q == S_SHIFTIR) begin
         serialOut = opShift_q[0];
      end else if (op_q == `OP_IDREAD) begin
         serialOut = idShift_q[0];
      end else if (chainSel) begin
         serialOut = chain_q[1];
      end else begin
         serialOut = shortcut_q;
      end
   end

   // TDO updated on falling TCK only
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         tdo     <= 1'b0;
         tdoEn_n <= 1'b1;
      end else if (tckFall) begin
         tdo     <= serialOut;
         tdoEn_n <= ~((state_q == S_SHIFTDR) | (state_q == S_SHIFTIR));
      end
   end

   assign tapState = state_q;
   assign opcode   = op_q;
endmodule

// >>> sim/sram_tap_props.sv
// Checker of the test access port relations seen at the block's ports
`timescale 1ns/1ns
`include "sram_tap_regs.vh"
module sram_tap_props (
   input wire                 mclk,
   input wire                 rst,
   input wire                 tck,
   input wire                 tdo,
   input wire                 tdoEn_n,
   input wire                 pinsFromScan,
   input wire                 memOutFloat,
   input wire                 outDataLost,
   input wire [3:0]           tapState,
   input wire [`OP_WIDTH-1:0] opcode
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Capture-DR then the state that follows it
   sequence s_capDr;
      tapState == 4'h6;
   endsequence
   sequence s_leftCap;
      tapState != 4'h6;
   endsequence
   property p_extest;
      pinsFromScan == (opcode == 3'h0);
   endproperty
   property p_float;
      memOutFloat == (opcode == 3'h2);
   endproperty
   property p_lost;
      (opcode == 3'h0) |-> ##[0:1] outDataLost;
   endproperty
   property p_tlrOp;
      (tapState == 4'hF) |=> (opcode == 3'h1);
   endproperty
   property p_opUpd;
      $changed(opcode) |-> (tapState == 4'hD) || (tapState == 4'hF);
   endproperty
   property p_tdoFall;
      $changed(tdo) |-> !tck && !$past(tck);
   endproperty
   property p_tdoEn;
      $fell(tdoEn_n) |-> (tapState == 4'h2) || (tapState == 4'hA);
   endproperty
   property p_capSeq;
      s_capDr ##1 s_leftCap |-> (tapState == 4'h2) || (tapState == 4'h1);
   endproperty
   a_extest: assert property (p_extest) else $error("pins not from scan cells");
   a_float: assert property (p_float) else $error("outputs not floated");
   a_lost: assert property (p_lost) else $error("output data flag missing");
   a_tlrOp: assert property (p_tlrOp) else $error("opcode not reset");
   a_opUpd: assert property (p_opUpd) else $error("opcode moved outside update");
   a_tdoFall: assert property (p_tdoFall) else $error("tdo moved with tck high");
   a_tdoEn: assert property (p_tdoEn) else $error("tdo enabled outside shift");
   a_capSeq: assert property (p_capSeq) else $error("bad exit from capture");
endmodule
bind sram_boundary_scan_tap sram_tap_props u_props (.mclk(mclk), .rst(rst), .tck(tck),
   .tdo(tdo), .tdoEn_n(tdoEn_n), .pinsFromScan(pinsFromScan), .memOutFloat(memOutFloat),
   .outDataLost(outDataLost), .tapState(tapState), .opcode(opcode));

// >>> sim/scan_ctl_model.sv
// Model of the external scan controller that drives the test pins
`timescale 1ns/1ns
module scan_ctl_model (
   input  wire mclk,
   input  wire tdo,
   output reg  tck,
   output reg  tms,
   output reg  tdi
);
   reg [119:0] seen;
   // Pins rest at their pulled-up levels, tck stands low
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      seen = 120'h0;
   end
   // One frame of n clocks, 48 ns each; levels change after each fall
   task frame(input integer n, input [119:0] mv, input [119:0] dv);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1) begin
            tms <= mv[i];
            tdi <= dv[i];
            repeat (6) @(posedge mclk);
            tck <= 1'b1;
            seen[i] = tdo;
            repeat (6) @(posedge mclk);
            tck <= 1'b0;
         end
         tdi <= 1'b1;
         repeat (8) @(posedge mclk);
         tms <= 1'b1;
         @(posedge mclk);
      end
   endtask
endmodule

// >>> sim/sram_boundary_scan_tap_tb.sv
// Self-checking bench of the boundary-scan test access port
`timescale 1ns/1ns
`include "sram_tap_regs.vh"
module sram_boundary_scan_tap_tb;
   reg                    mclk, rst, sampleValid;
   reg  [`CHAIN_LEN-1:0]  pinIn, sampleData, pat;
   wire                   tck, tms, tdi, tdo, tdoEn_n, sampleReady;
   wire                   pinsFromScan, memOutFloat, outDataLost;
   wire [`CHAIN_LEN-1:0]  pinOut;
   wire [3:0]             tapState;
   wire [`OP_WIDTH-1:0]   opcode;
   reg  [8:0]             rows [0:7];
   integer                bad_count, check_count, cycles, r;
   sram_boundary_scan_tap u_dut (.mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdoEn_n(tdoEn_n), .pinIn(pinIn), .sampleData(sampleData),
      .sampleValid(sampleValid), .sampleReady(sampleReady), .pinOut(pinOut),
      .pinsFromScan(pinsFromScan), .memOutFloat(memOutFloat), .outDataLost(outDataLost),
      .tapState(tapState), .opcode(opcode));
   scan_ctl_model u_ctl (.mclk(mclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
   // 250 MHz clock and a cycle ceiling
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial cycles = 0;
   always @(posedge mclk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         conclude;
      end
   end
   task check(input [119:0] s, input [119:0] e);
      begin
         check_count = check_count + 1;
         if (s !== e) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
         end
      end
   endtask
   task conclude;
      begin
         $display("checks %0d mismatches %0d", check_count, bad_count);
         if (bad_count == 0 && check_count > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // Instruction scan from Idle back to Idle, LSB first
   task ir(input [2:0] c);
      u_ctl.frame(9, 120'h0C3, {117'h0, c} << 4);
   endtask
   // Data scan of n bits from Idle back to Idle
   task dr(input integer n, input [119:0] d);
      u_ctl.frame(n + 5, 120'h1 | (120'h3 << (n + 2)), d << 3);
   endtask
   // Rows: opcode, first four bits out, pins from scan, outputs floated
   initial begin
      rows[0] = {3'h0, 4'hA, 2'h2};
      rows[1] = {3'h1, 4'h1, 2'h0};
      rows[2] = {3'h2, 4'hA, 2'h1};
      rows[3] = {3'h7, 4'h6, 2'h0};
      rows[4] = {3'h4, 4'hA, 2'h0};
      rows[5] = {3'h1, 4'h1, 2'h0};
      rows[6] = {3'h2, 4'hA, 2'h1};
      rows[7] = {3'h7, 4'h6, 2'h0};
      rst = 1'b1;
      pinIn = {1'b1, {27{4'hA}}};
      pat = ~pinIn;
      sampleData = 0;
      sampleValid = 1'b0;
      bad_count = 0;
      check_count = 0;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      check(opcode, `OP_RESET);
      check(tapState, 4'hF);
      check({tdoEn_n, sampleReady, outDataLost}, 3'h6);
      $display("test reset done");
      u_ctl.frame(1, 120'h0, 120'h0);
      for (r = 0; r < 8; r = r + 1) begin
         ir(rows[r][8:6]);
         check(u_ctl.seen[6:4], `OP_CAPTURE);
         check(opcode, rows[r][8:6]);
         check(pinsFromScan, rows[r][1]);
         check(memOutFloat, rows[r][0]);
         dr(4, 120'hB);
         check(u_ctl.seen[6:3], rows[r][5:2]);
      end
      check(outDataLost, 1'b1);
      $display("test opcode table done");
      ir(`OP_SAMPLE);
      dr(`CHAIN_LEN, pat);
      check(u_ctl.seen[111:3], pinIn);
      ir(`OP_EXTEST);
      check({pinsFromScan, pinOut}, {1'b1, pat});
      $display("test preload and drive done");
      sampleData <= pat;
      sampleValid <= 1'b1;
      r = 0;
      repeat (10) begin
         @(posedge mclk);
         if (sampleReady === 1'b1) r = r + 1;
      end
      sampleValid <= 1'b0;
      check(r, `FIFO_DEPTH);
      check(sampleReady, 1'b0);
      dr(4, 120'h0);
      check(u_ctl.seen[6:3], 4'h5);
      check(sampleReady, 1'b1);
      $display("test sample queue done");
      ir(`OP_BYPASS);
      u_ctl.frame(5, 120'h1F, 120'h0);
      check({tapState, opcode}, {4'hF, `OP_RESET});
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      check(outDataLost, 1'b0);
      $display("test tms reset done");
      conclude;
   end
endmodule
